// >>> fgc_pkg.sv
// constants shared by the gauge second-configuration block
package fgc_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [7:0]  CFG_ADDR      = 8'hbb;
  localparam logic [7:0]  IRQ_STAT_ADDR = 8'hc0;
  localparam logic [7:0]  IRQ_MASK_ADDR = 8'hc1;
  localparam logic [7:0]  ACT_ADDR      = 8'hc2;
  // field positions of gauge_config_second
  localparam int          B_PRED   = 13;
  localparam int          B_PEAK   = 12;
  localparam int          B_PWR_LO = 8;
  localparam int          B_SOC    = 7;
  localparam int          B_TEMP   = 6;
  localparam int          B_LD     = 5;
  localparam int          B_RLX_LO = 2;
  localparam int          B_CP     = 1;
  // reset value and the writable / readable positions
  localparam logic [15:0] CFG_RESET = 16'h3440;
  localparam logic [15:0] CFG_WMASK = 16'h3fee;
  // interrupt status bit positions
  localparam int          IRQ_MODEL = 0;
  localparam int          IRQ_SOC   = 1;
  localparam int          IRQ_TEMP  = 2;
  localparam int          IRQ_W     = 3;
  localparam logic [2:0]  IRQ_RESET = 3'h0;
  // power time constant is 2^field units of 45 s / 2^6
  localparam logic [15:0] PWR_TC_ONE   = 16'h0001;
  // relax window edges in minutes: 0.8 h and 1.6 h times 2^field
  localparam logic [9:0]  RLX_MIN_BASE = 10'h030;
  localparam logic [9:0]  RLX_MAX_BASE = 10'h060;
  // divider steps in the constant-power scaler
  localparam logic [5:0]  DIV_STEPS    = 6'h20;
endpackage

// >>> fgc_scale_if.sv
// request and answer between the register block and the scaler
interface fgc_scale_if;
  logic               start;
  logic signed [15:0] cur;
  logic        [15:0] vcell;
  logic        [15:0] empty_voltage_threshold;
  logic               busy;
  logic               done;
  logic signed [15:0] result;
  modport master (output start, cur, vcell, empty_voltage_threshold, input busy, done, result);
  modport unit   (input start, cur, vcell, empty_voltage_threshold, output busy, done, result);
endinterface

// >>> fgc_cp_scale.sv
// constant-power current scaler: cur * v / (v + ve) / 2
module fgc_cp_scale
  import fgc_pkg::*;
(
  input  wire logic   sys_clk_i, // system clock
  input  wire logic   rst_i,     // async reset, high
  input  wire logic   ce_i,      // clock enable
  fgc_scale_if.unit   sc         // request and answer
);
  typedef struct packed {
    logic               busy;
    logic [5:0]         cnt;
    logic [32:0]        rem;
    logic [31:0]        quo;
    logic [16:0]        den;
    logic               neg;
    logic               done;
    logic signed [15:0] result;
  } fgc_scale_st_t;

  fgc_scale_st_t st;
  fgc_scale_st_t next_st;

  // restoring division, one quotient bit a cycle
  always_comb begin
    logic [15:0] mag;
    logic [32:0] trial;
    logic [15:0] q;
    mag = 16'h0000;
    trial = 33'h0;
    q = 16'h0000;
    next_st = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      trial = {st.rem[31:0], st.quo[31]};
      next_st.quo = {st.quo[30:0], 1'b0};
      if (trial >= {16'h0000, st.den}) begin
        trial = trial - {16'h0000, st.den};
        next_st.quo[0] = 1'b1;
      end
      next_st.rem = trial;
      next_st.cnt = st.cnt - 6'h01;
      if (st.cnt == 6'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        q = (st.den == 17'h0) ? 16'h0000 : next_st.quo[16:1]; // halved
        next_st.result = st.neg ? -$signed(q) : $signed(q);
      end
    end else if (sc.start) begin
      mag = sc.cur[15] ? 16'(-sc.cur) : sc.cur;
      next_st.busy = 1'b1;
      next_st.cnt = DIV_STEPS;
      next_st.rem = 33'h0;
      next_st.quo = mag * sc.vcell;
      next_st.den = {1'b0, sc.vcell} + {1'b0, sc.empty_voltage_threshold};
      next_st.neg = sc.cur[15];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign sc.busy = st.busy;
  assign sc.done = st.done;
  assign sc.result = st.result;

  sequence scale_req_s;
    ce_i && sc.start && !st.busy;
  endsequence
  sequence scale_run_s;
    st.busy [*8];
  endsequence

  // answer comes a fixed number of enabled steps after the request
  scale_latency_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    scale_req_s ##1 scale_run_s |-> (ce_i == 1'b0) or ##[24:300] st.done)
    else $error("scaler answer missing");
endmodule

// >>> fgc_gauge_config_second.sv
// gauge second configuration register with alert, model-load and scaling logic
// Notes on behaviour
// - a changed enable takes effect at the next gauge task tick, within one task period.
// - with the prediction enable at zero the prediction engine is stopped; reset value one.
// - with the peak-power enable at zero the peak-power engine is stopped; reset value one.
// - the power filter field sets the time constant to 45 s times 2 to the field minus six.
// - the alert follows the charge-change flag only while its enable is one; reset zero.
// - temperature alerts pass only while their enable is one; reset one.
// - software sets the model-load position, firmware clears it when processing ends.
// - the relax field picks a window of 0.8 h times 2 to the field up to twice that.
// - with constant power the current is scaled by v over v plus empty voltage, halved.
module fgc_gauge_config_second
  import fgc_pkg::*;
(
  input  wire logic               sys_clk_i,                 // system clock, 125 MHz
  input  wire logic               rst_i,                     // async reset, high
  input  wire logic               ce_i,                      // clock enable, freezes state
  input  wire logic [7:0]         addr_i,                    // register address
  input  wire logic [15:0]        wdata_i,                   // write data
  input  wire logic               wr_i,                      // write strobe
  input  wire logic               rd_i,                      // read strobe
  output      logic [15:0]        rdata_o,                   // read data, cycle after rd_i
  input  wire logic               task_tick_i,               // gauge task period tick
  input  wire logic               fw_model_done_i,           // firmware ends model load
  input  wire logic               charge_change_flag_i,      // charge-change status flag
  input  wire logic               temp_alert_event_i,        // raw temperature alert
  input  wire logic signed [15:0] load_current_i,            // prediction or average current
  input  wire logic [15:0]        filtered_cell_voltage_i,   // averaged cell voltage
  input  wire logic [15:0]        empty_voltage_threshold_i, // empty voltage, same scale
  output      logic               prediction_calc_enable_o,  // prediction engine run
  output      logic               peak_power_calc_enable_o,  // peak-power engine run
  output      logic [3:0]         power_filter_constant_o,   // applied filter field
  output      logic [15:0]        power_time_const_o,        // time constant, 703.125 ms units
  output      logic               temperature_alert_enable_o, // applied temp enable
  output      logic               model_load_request_o,      // model load pending
  output      logic [1:0]         deep_relax_window_o,       // applied relax field
  output      logic [9:0]         relax_min_minutes_o,       // relax window lower edge
  output      logic [9:0]         relax_max_minutes_o,       // relax window upper edge
  output      logic               constant_power_select_o,   // applied constant-power mode
  output      logic signed [15:0] estimate_current_o,        // current for time estimates
  output      logic               alert_o,                   // gated alert output
  output      logic               irq_o                      // interrupt level
);
  typedef struct packed {
    logic [15:0]        cfg;
    logic [15:0]        act;
    logic [IRQ_W-1:0]   stat;
    logic [IRQ_W-1:0]   mask;
    logic [15:0]        rdata;
    logic [15:0]        pwr_tc;
    logic [9:0]         rlx_min;
    logic [9:0]         rlx_max;
    logic               start;
    logic signed [15:0] raw;
    logic signed [15:0] est;
    logic               alert;
    logic               irq;
  } fgc_cfg_st_t;

  fgc_cfg_st_t st;
  fgc_cfg_st_t next_st;
  fgc_scale_if sc ();

  // scaler request: current from the latched sample, voltages straight from the inputs
  assign sc.start = st.start;
  assign sc.cur = st.raw;
  assign sc.vcell = filtered_cell_voltage_i;
  assign sc.empty_voltage_threshold = empty_voltage_threshold_i;

  fgc_cp_scale u_scale (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .sc        (sc)
  );

  // next state of the whole block
  always_comb begin
    logic             cfg_wr;
    logic [IRQ_W-1:0] ev;
    cfg_wr = wr_i && (addr_i == CFG_ADDR);
    ev = '0;
    next_st = st;
    next_st.start = 1'b0;
    next_st.rdata = 16'h0000;
    // software write: reserved positions never stored
    if (cfg_wr) begin
      next_st.cfg = (wdata_i & CFG_WMASK) | (st.cfg & 16'(1 << B_LD));
      next_st.cfg[B_LD] = st.cfg[B_LD] | wdata_i[B_LD];
    end
    // firmware clear loses to a same-cycle software set
    if (fw_model_done_i && st.cfg[B_LD] && !(cfg_wr && wdata_i[B_LD])) begin
      next_st.cfg[B_LD] = 1'b0;
      ev[IRQ_MODEL] = 1'b1;
    end
    // configuration takes effect at the task tick
    if (task_tick_i) begin
      next_st.act = next_st.cfg;
      next_st.pwr_tc = PWR_TC_ONE << next_st.cfg[B_PWR_LO +: 4];
      next_st.rlx_min = RLX_MIN_BASE << next_st.cfg[B_RLX_LO +: 2];
      next_st.rlx_max = RLX_MAX_BASE << next_st.cfg[B_RLX_LO +: 2];
      if (!sc.busy && !st.start) begin
        next_st.start = 1'b1;
        next_st.raw = load_current_i;
      end
    end
    // estimate current chosen by the applied mode
    if (sc.done) begin
      next_st.est = st.act[B_CP] ? sc.result : st.raw;
    end
    // gated alerts set sticky status
    ev[IRQ_SOC] = charge_change_flag_i && st.act[B_SOC];
    ev[IRQ_TEMP] = temp_alert_event_i && st.act[B_TEMP];
    next_st.alert = ev[IRQ_SOC] || ev[IRQ_TEMP];
    if (wr_i && (addr_i == IRQ_STAT_ADDR)) begin
      next_st.stat = st.stat & ~wdata_i[IRQ_W-1:0];
    end else if (wr_i && (addr_i == IRQ_MASK_ADDR)) begin
      next_st.mask = wdata_i[IRQ_W-1:0];
    end
    next_st.stat = next_st.stat | ev;
    next_st.irq = |(next_st.stat & next_st.mask);
    // read data, zero for unmapped addresses
    if (rd_i) begin
      if (addr_i == CFG_ADDR) begin
        next_st.rdata = st.cfg & CFG_WMASK;
      end else if (addr_i == IRQ_STAT_ADDR) begin
        next_st.rdata = {13'h0000, st.stat};
      end else if (addr_i == IRQ_MASK_ADDR) begin
        next_st.rdata = {13'h0000, st.mask};
      end else if (addr_i == ACT_ADDR) begin
        next_st.rdata = st.act;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.cfg <= CFG_RESET;
      st.act <= CFG_RESET;
      st.stat <= IRQ_RESET;
      st.mask <= IRQ_RESET;
      st.rdata <= 16'h0000;
      st.pwr_tc <= PWR_TC_ONE << CFG_RESET[B_PWR_LO +: 4];
      st.rlx_min <= RLX_MIN_BASE << CFG_RESET[B_RLX_LO +: 2];
      st.rlx_max <= RLX_MAX_BASE << CFG_RESET[B_RLX_LO +: 2];
      st.start <= 1'b0;
      st.raw <= 16'sh0000;
      st.est <= 16'sh0000;
      st.alert <= 1'b0;
      st.irq <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rdata_o = st.rdata;
  assign prediction_calc_enable_o = st.act[B_PRED];
  assign peak_power_calc_enable_o = st.act[B_PEAK];
  assign power_filter_constant_o = st.act[B_PWR_LO +: 4];
  assign power_time_const_o = st.pwr_tc;
  assign temperature_alert_enable_o = st.act[B_TEMP];
  assign model_load_request_o = st.cfg[B_LD];
  assign deep_relax_window_o = st.act[B_RLX_LO +: 2];
  assign relax_min_minutes_o = st.rlx_min;
  assign relax_max_minutes_o = st.rlx_max;
  assign constant_power_select_o = st.act[B_CP];
  assign estimate_current_o = st.est;
  assign alert_o = st.alert;
  assign irq_o = st.irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence cfg_write_s;
    ce_i && wr_i && (addr_i == CFG_ADDR);
  endsequence

  reserved_zero_a: assert property ((st.cfg & ~CFG_WMASK) == 16'h0000)
    else $error("reserved config position stored");
  apply_at_tick_a: assert property (ce_i && task_tick_i |=> st.act == $past(next_st.cfg))
    else $error("config not applied at tick");
  hold_off_tick_a: assert property (ce_i && !task_tick_i |=> $stable(st.act))
    else $error("applied config moved between ticks");
  engines_follow_a: assert property (ce_i && task_tick_i |=>
    prediction_calc_enable_o == $past(next_st.cfg[B_PRED])
    && peak_power_calc_enable_o == $past(next_st.cfg[B_PEAK]))
    else $error("engine enable mismatch");
  power_const_a: assert property (power_time_const_o ==
    (PWR_TC_ONE << power_filter_constant_o))
    else $error("power time constant mismatch");
  relax_window_a: assert property (relax_max_minutes_o ==
    (relax_min_minutes_o << 1) && relax_min_minutes_o == (RLX_MIN_BASE << deep_relax_window_o))
    else $error("relax window mismatch");
  alert_gate_a: assert property (ce_i |=> alert_o == $past(
    (charge_change_flag_i && st.act[B_SOC]) || (temp_alert_event_i && st.act[B_TEMP])))
    else $error("alert gating wrong");
  model_set_a: assert property (cfg_write_s ##0 wdata_i[B_LD] |=> model_load_request_o)
    else $error("model load not set");
  model_clear_a: assert property (ce_i && fw_model_done_i && !(wr_i && addr_i == CFG_ADDR)
    |=> !model_load_request_o ##0 st.stat[IRQ_MODEL] == $past(st.cfg[B_LD]) || $past(st.stat[IRQ_MODEL]))
    else $error("model load not cleared");
  direct_mode_a: assert property (ce_i && sc.done && !st.act[B_CP] |=>
    estimate_current_o == $past(st.raw))
    else $error("direct current altered");
  low_bits_read_a: assert property (ce_i && rd_i && addr_i == CFG_ADDR |=>
    rdata_o[4] == 1'b0 && rdata_o[0] == 1'b0 && rdata_o[15:14] == 2'b00)
    else $error("reserved read not zero");
endmodule

// >>> fgc_gauge_config_second_tb.sv
// self-checking testbench for the gauge second configuration register block
module fgc_gauge_config_second_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fgc_pkg::*;

  logic               sys_clk_i;
  logic               rst_i;
  logic               ce_i;
  logic [7:0]         addr_i;
  logic [15:0]        wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [15:0]        rdata_o;
  logic               task_tick_i;
  logic               fw_model_done_i;
  logic               charge_change_flag_i;
  logic               temp_alert_event_i;
  logic signed [15:0] load_current_i;
  logic [15:0]        filtered_cell_voltage_i;
  logic [15:0]        empty_voltage_threshold_i;
  logic               pred_o, peak_o, temp_en_o, model_o, cp_o, alert_o, irq_o;
  logic [3:0]         pwr_o;
  logic [15:0]        tc_o;
  logic [1:0]         rlx_o;
  logic [9:0]         rmin_o, rmax_o;
  logic signed [15:0] est_o;
  logic [15:0]        rv;
  int                 mismatches = 0;
  int                 tests_run  = 0;

  fgc_gauge_config_second u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .task_tick_i(task_tick_i), .fw_model_done_i(fw_model_done_i),
    .charge_change_flag_i(charge_change_flag_i), .temp_alert_event_i(temp_alert_event_i),
    .load_current_i(load_current_i), .filtered_cell_voltage_i(filtered_cell_voltage_i),
    .empty_voltage_threshold_i(empty_voltage_threshold_i),
    .prediction_calc_enable_o(pred_o), .peak_power_calc_enable_o(peak_o),
    .power_filter_constant_o(pwr_o), .power_time_const_o(tc_o),
    .temperature_alert_enable_o(temp_en_o), .model_load_request_o(model_o),
    .deep_relax_window_o(rlx_o), .relax_min_minutes_o(rmin_o), .relax_max_minutes_o(rmax_o),
    .constant_power_select_o(cp_o), .estimate_current_o(est_o), .alert_o(alert_o),
    .irq_o(irq_o)
  );

  // 125 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // compare one result, count it, report a mismatch
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // one gauge task period tick, applied copy lands on the sampling edge
  task automatic tick();
    @(posedge sys_clk_i);
    task_tick_i <= 1'b1;
    @(posedge sys_clk_i);
    task_tick_i <= 1'b0;
    #1;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // reset values of the stored and applied settings
  task automatic t_reset();
    rd(CFG_ADDR, rv);
    chk("cfg reset", 16'h3440, rv);
    chk("pred reset", 16'h0001, pred_o);
    chk("peak reset", 16'h0001, peak_o);
    chk("tc reset", 16'h0010, tc_o);
    chk("filter reset", 16'h0004, pwr_o);
    chk("temp en reset", 16'h0001, temp_en_o);
    chk("relax min reset", 16'h0030, rmin_o);
  endtask

  // reserved positions, apply at tick, field decode table
  task automatic t_fields();
    logic [15:0] c;
    wr(CFG_ADDR, 16'h3fdf);
    rd(CFG_ADDR, rv);
    chk("cfg reserved", 16'h3fce, rv);
    chk("cp before tick", 16'h0000, cp_o);
    tick();
    chk("cp after tick", 16'h0001, cp_o);
    chk("tc field f", 16'h8000, tc_o);
    chk("relax max f3", 16'h0300, rmax_o);
    for (int k = 0; k < 4; k++) begin
      c = (16'(k) << 8) | (16'(k) << 2);
      wr(CFG_ADDR, c);
      tick();
      chk("pred off", 16'h0000, pred_o);
      chk("peak off", 16'h0000, peak_o);
      chk("tc table", 16'h0001 << k, tc_o);
      chk("filter field", 16'(k), pwr_o);
      chk("relax field", 16'(k), rlx_o);
      chk("relax min", 16'h0030 << k, rmin_o);
      chk("relax max", 16'h0060 << k, rmax_o);
      rd(ACT_ADDR, rv);
      chk("applied copy", c, rv);
    end
  endtask

  // alert gating by the two alert enables
  task automatic t_alert();
    wr(CFG_ADDR, 16'h0000);
    tick();
    charge_change_flag_i <= 1'b1;
    temp_alert_event_i   <= 1'b1;
    cycles(3);
    chk("alert gated", 16'h0000, alert_o);
    rd(IRQ_STAT_ADDR, rv);
    chk("gated status", 16'h0000, rv);
    wr(CFG_ADDR, 16'h0080);
    tick();
    cycles(2);
    chk("soc alert", 16'h0001, alert_o);
    charge_change_flag_i <= 1'b0;
    cycles(3);
    chk("temp gated", 16'h0000, alert_o);
    wr(CFG_ADDR, 16'h0040);
    tick();
    cycles(2);
    chk("temp alert", 16'h0001, alert_o);
    temp_alert_event_i <= 1'b0;
    cycles(3);
    chk("alert drop", 16'h0000, alert_o);
    rd(IRQ_STAT_ADDR, rv);
    chk("alert status", 16'h0006, rv);
  endtask

  // model load handshake, status, mask and interrupt
  task automatic t_model();
    wr(IRQ_STAT_ADDR, 16'h0007);
    wr(IRQ_MASK_ADDR, 16'h0001);
    wr(CFG_ADDR, 16'h0020);
    chk("model set", 16'h0001, model_o);
    wr(CFG_ADDR, 16'h0000);
    chk("model kept", 16'h0001, model_o);
    @(posedge sys_clk_i);
    fw_model_done_i <= 1'b1;
    @(posedge sys_clk_i);
    fw_model_done_i <= 1'b0;
    cycles(3);
    chk("model cleared", 16'h0000, model_o);
    chk("irq raised", 16'h0001, irq_o);
    rd(IRQ_STAT_ADDR, rv);
    chk("status model", 16'h0001, rv & 16'h0001);
    wr(IRQ_STAT_ADDR, 16'h0001);
    cycles(2);
    chk("irq cleared", 16'h0000, irq_o);
    wr(IRQ_MASK_ADDR, 16'h0000);
    wr(CFG_ADDR, 16'h0020);
    @(posedge sys_clk_i);
    fw_model_done_i <= 1'b1;
    @(posedge sys_clk_i);
    fw_model_done_i <= 1'b0;
    cycles(3);
    chk("irq masked", 16'h0000, irq_o);
  endtask

  // estimate current with constant power off and on
  task automatic t_cp(input logic [15:0] cfg, input logic signed [15:0] cur,
                      input logic [15:0] v, input logic [15:0] ve, input logic [15:0] exp);
    load_current_i            <= cur;
    filtered_cell_voltage_i   <= v;
    empty_voltage_threshold_i <= ve;
    wr(CFG_ADDR, cfg);
    tick();
    cycles(40);
    chk("estimate", exp, est_o);
  endtask

  // unmapped and read-only addresses, read data lasts one cycle
  task automatic t_map();
    rd(8'h10, rv);
    chk("unmapped read", 16'h0000, rv);
    wr(8'h10, 16'hffff);
    wr(ACT_ADDR, 16'hffff);
    rd(ACT_ADDR, rv);
    chk("act read only", 16'h0002, rv);
    rd(CFG_ADDR, rv);
    chk("stray writes", 16'h0002, rv);
    cycles(1);
    chk("rdata one cycle", 16'h0000, rdata_o);
  endtask

  // clock enable low freezes writes and ticks
  task automatic t_freeze();
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(CFG_ADDR, 16'h000c);
    tick();
    chk("frozen relax", 16'h0000, rlx_o);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rd(CFG_ADDR, rv);
    chk("frozen write", 16'h0002, rv);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    task_tick_i = 1'b0;
    fw_model_done_i = 1'b0;
    charge_change_flag_i = 1'b0;
    temp_alert_event_i = 1'b0;
    load_current_i = 16'sh0000;
    filtered_cell_voltage_i = 16'h0000;
    empty_voltage_threshold_i = 16'h0000;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_alert();
    t_model();
    t_cp(16'h0002, 16'sh03e8, 16'h0bb8, 16'h03e8, 16'h0177);
    t_cp(16'h0000, 16'sh03e8, 16'h0bb8, 16'h03e8, 16'h03e8);
    t_cp(16'h0002, -16'sh03e8, 16'h0bb8, 16'h0bb8, 16'hff06);
    t_map();
    t_freeze();
    close_out();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
endmodule
